// File: design/mcidec_core.sv
`timescale 1ns/10ps
// Summary of operation
// - Program counter change costs two cycles, second one idle.
// - Indirect port access with pointer top bit set adds one cycle.
// - Decode pc-relative jump (9-bit signed) and accumulator-relative jump.
// - Decode subroutine invoke, absolute jump, accumulator-indexed invoke; two cycles.
// - Interrupt exit pops return address in two cycles.
// - Plain return pops return address into program counter, two cycles.
// - Return with literal loads accumulator and returns, two cycles.
// - Watchdog kick clears watchdog, sets timeout and power-down flags.
// - Standby entry sets timeout flag, clears power-down flag, enters standby.
// - Software reset instruction resets core state, but not bus state, last instruction or cycle count.
// - Load-configuration copies accumulator into prescale configuration register.
// - Load-direction copies accumulator into selected direction register.
// - Pointer-add-literal selects pointer by n, one cycle, no status change.
// - Pointer-add-literal adds signed 6-bit field to full 16-bit pointer.
// - Pointer arithmetic wraps modulo 16 bits.
// - Indirect load with modifier updates accumulator, pointer and zero flag.
// - Indexed indirect load reads pointer plus offset, updates zero flag.
// - Indirect store with modifier writes accumulator, no status change.
// - Indexed indirect store writes accumulator at pointer plus offset.
// - And-literal updates accumulator and zero flag only.
// - Add-literal updates accumulator, carry, digit carry and zero.
// - And-with-file writes accumulator or file by d, zero flag only.
module mcidec_core #(
	parameter int DMEM_DEPTH = 128, // Data memory bytes
	parameter int STACK_DEPTH = 16 // Return stack entries
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [mcidec_pkg::ADDR_W-1:0] awaddr, // Write address
	input wire logic [2:0] awprot, // Unused protection
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Byte enables
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [mcidec_pkg::ADDR_W-1:0] araddr, // Read address
	input wire logic [2:0] arprot, // Unused protection
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	output logic wdt_clear, // Watchdog clear pulse
	output logic standby, // Standby mode level
	output logic soft_reset, // Software reset pulse
	output logic [7:0] config_out, // Timer prescale configuration
	output logic [63:0] dir_out // Eight pin direction registers
);
	localparam int MAW = $clog2(DMEM_DEPTH);
	localparam int SPW = $clog2(STACK_DEPTH);
	localparam int PW = mcidec_pkg::PTR_W;
	localparam int CW = mcidec_pkg::PC_W;

	initial begin
		if (DMEM_DEPTH < 128 || DMEM_DEPTH > 65536 || (1 << MAW) != DMEM_DEPTH)
			$error("DMEM_DEPTH must be a power of two from 128 to 65536");
		if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH)
			$error("STACK_DEPTH must be a power of two of at least 2");
	end

	// ************************
	// State
	// ************************
	logic [7:0] acc, next_acc;
	mcidec_pkg::mcidec_status_t st, next_st;
	logic [PW-1:0] ptr0, ptr1, next_ptr0, next_ptr1;
	logic [CW-1:0] pc, next_pc;
	logic [SPW-1:0] sp, next_sp;
	logic [CW-1:0] stack [STACK_DEPTH];
	logic [7:0] mem [DMEM_DEPTH];
	logic [7:0] dir_reg [8];
	logic [PW-1:0] mem_addr, next_mem_addr;
	logic [13:0] last_ins;
	logic [1:0] busy_cnt, last_cyc, cyc;
	logic aw_rdy, ar_rdy, w_fire, r_fire, exec, w_ok;
	logic push, mem_we, cfg_we, dir_we, kick, stby, swrst, pc_chg, ind_extra;
	logic [CW-1:0] push_val;
	logic [PW-1:0] mem_wa, ea, ptr_cur, ptr_step;
	logic [7:0] mem_wd, mem_rd, rd_data_lo;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [13:0] ins;
	mcidec_pkg::mcidec_op_t op;

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic mcidec_pkg::mcidec_op_t op_decode(input logic [13:0] i);
		mcidec_pkg::mcidec_op_t o;
		o = mcidec_pkg::OP_IDLE;
		if (i == mcidec_pkg::OPC_SWRESET) o = mcidec_pkg::OP_SWRESET;
		else if (i == mcidec_pkg::OPC_RETURN) o = mcidec_pkg::OP_RETURN;
		else if (i == mcidec_pkg::OPC_INTEXIT) o = mcidec_pkg::OP_INTEXIT;
		else if (i == mcidec_pkg::OPC_ACC_INDEXED_INVOKE) o = mcidec_pkg::OP_ACC_INDEXED_INVOKE;
		else if (i == mcidec_pkg::OPC_BRW) o = mcidec_pkg::OP_BRW;
		else if (i == mcidec_pkg::OPC_CONFIG) o = mcidec_pkg::OP_CONFIG;
		else if (i == mcidec_pkg::OPC_STANDBY) o = mcidec_pkg::OP_STANDBY;
		else if (i == mcidec_pkg::OPC_KICK) o = mcidec_pkg::OP_KICK;
		else if (i[13:3] == mcidec_pkg::PFX_DIR) o = mcidec_pkg::OP_DIR;
		else if (i[13:4] == mcidec_pkg::PFX_IND_MOD)
			o = i[3] ? mcidec_pkg::OP_STORE_MOD : mcidec_pkg::OP_LOAD_MOD;
		else if (i[13:9] == mcidec_pkg::PFX_JREL) o = mcidec_pkg::OP_JREL;
		else if (i[13:11] == mcidec_pkg::PFX_INVOKE) o = mcidec_pkg::OP_INVOKE;
		else if (i[13:11] == mcidec_pkg::PFX_JABS) o = mcidec_pkg::OP_JABS;
		else if (i[13:8] == mcidec_pkg::PFX_RETLIT) o = mcidec_pkg::OP_RETLIT;
		else if (i[13:7] == mcidec_pkg::PFX_PADD) o = mcidec_pkg::OP_PADD;
		else if (i[13:8] == mcidec_pkg::PFX_IND_IDX)
			o = i[7] ? mcidec_pkg::OP_STORE_IDX : mcidec_pkg::OP_LOAD_IDX;
		else if (i[13:8] == mcidec_pkg::PFX_ANDLIT) o = mcidec_pkg::OP_ANDLIT;
		else if (i[13:8] == mcidec_pkg::PFX_ADDLIT) o = mcidec_pkg::OP_ADDLIT;
		else if (i[13:8] == mcidec_pkg::PFX_ANDFILE) o = mcidec_pkg::OP_ANDFILE;
		return o;
	endfunction

	// ************************
	// Bus slave
	// ************************
	// A new instruction is refused until the previous one has used its cycles
	assign w_fire = aw_rdy && awvalid && wvalid;
	assign r_fire = ar_rdy && arvalid;
	assign exec = w_fire && awaddr == mcidec_pkg::OFF_INSTR;
	assign awready = aw_rdy;
	assign wready = aw_rdy;
	assign arready = ar_rdy;

	always_comb begin
		unique case (awaddr)
			mcidec_pkg::OFF_INSTR, mcidec_pkg::OFF_ACC, mcidec_pkg::OFF_STATUS,
			mcidec_pkg::OFF_PTR0, mcidec_pkg::OFF_PTR1, mcidec_pkg::OFF_PC,
			mcidec_pkg::OFF_MEM_ADDR, mcidec_pkg::OFF_MEM_DATA: w_ok = 1'b1;
			default: w_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_rdy <= 1'b0;
			bvalid <= 1'b0;
			bresp <= mcidec_pkg::RESP_OKAY;
		end else begin
			aw_rdy <= !aw_rdy && awvalid && wvalid && !bvalid && busy_cnt == 2'h0;
			if (w_fire) begin
				bvalid <= 1'b1;
				bresp <= w_ok ? mcidec_pkg::RESP_OKAY : mcidec_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h0000_0000;
		if (araddr[7:5] == mcidec_pkg::OFF_DIR_BASE[7:5] && araddr[1:0] == 2'h0) begin
			rd_data = {24'h000000, dir_reg[araddr[4:2]]};
		end else begin
			unique case (araddr)
				mcidec_pkg::OFF_INSTR: rd_data = {18'h00000, last_ins};
				mcidec_pkg::OFF_ACC: rd_data = {24'h000000, acc};
				mcidec_pkg::OFF_STATUS: rd_data = {24'h000000, busy_cnt != 2'h0, st};
				mcidec_pkg::OFF_PTR0: rd_data = {16'h0000, ptr0};
				mcidec_pkg::OFF_PTR1: rd_data = {16'h0000, ptr1};
				mcidec_pkg::OFF_PC: rd_data = {17'h00000, pc};
				mcidec_pkg::OFF_CONFIG: rd_data = {24'h000000, config_out};
				mcidec_pkg::OFF_MEM_ADDR: rd_data = {16'h0000, mem_addr};
				mcidec_pkg::OFF_MEM_DATA: rd_data = {24'h000000, rd_data_lo};
				mcidec_pkg::OFF_CYCLES: rd_data = {30'h00000000, last_cyc};
				default: rd_ok = 1'b0;
			endcase
		end
	end
	assign rd_data_lo = mem[mem_addr[MAW-1:0]];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_rdy <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= mcidec_pkg::RESP_OKAY;
		end else begin
			ar_rdy <= !ar_rdy && arvalid && !rvalid;
			if (r_fire) begin
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rd_ok ? mcidec_pkg::RESP_OKAY : mcidec_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ************************
	// Effective address
	// ************************
	assign ins = wdata[13:0];
	assign op = op_decode(ins);

	always_comb begin
		ind_extra = 1'b0;
		ptr_cur = ptr0;
		ea = ptr0;
		unique case (op)
			mcidec_pkg::OP_LOAD_MOD, mcidec_pkg::OP_STORE_MOD: begin
				ptr_cur = ins[2] ? ptr1 : ptr0;
				ea = ins[1] ? ptr_cur : ptr_step;
				ind_extra = ptr_cur[PW-1];
			end
			mcidec_pkg::OP_LOAD_IDX, mcidec_pkg::OP_STORE_IDX, mcidec_pkg::OP_PADD: begin
				ptr_cur = ins[6] ? ptr1 : ptr0;
				ea = ptr_cur + {{10{ins[5]}}, ins[5:0]};
				ind_extra = ptr_cur[PW-1] && op != mcidec_pkg::OP_PADD;
			end
			mcidec_pkg::OP_ANDFILE: begin
				ptr_cur = ins[0] ? ptr1 : ptr0;
				// Addresses 0 and 1 are the indirect access ports
				if (ins[6:0] <= mcidec_pkg::F_PORT1) begin
					ea = ptr_cur;
					ind_extra = ptr_cur[PW-1];
				end else begin
					ea = {9'h000, ins[6:0]};
				end
			end
			default: ea = ptr0;
		endcase
	end
	// Modifier bit0 picks decrement, wrapping in 16 bits
	assign ptr_step = ins[0] ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001;
	assign mem_rd = mem[ea[MAW-1:0]];

	// ************************
	// Execute
	// ************************
	always_comb begin
		logic [8:0] sum;
		logic [4:0] hsum;
		logic [7:0] res;
		sum = {1'b0, acc} + {1'b0, ins[7:0]};
		hsum = {1'b0, acc[3:0]} + {1'b0, ins[3:0]};
		res = acc & mem_rd;
		next_acc = acc;
		next_st = st;
		next_ptr0 = ptr0;
		next_ptr1 = ptr1;
		next_pc = pc + 15'h0001;
		next_sp = sp;
		next_mem_addr = mem_addr;
		push = 1'b0;
		push_val = pc + 15'h0001;
		mem_we = 1'b0;
		mem_wa = ea;
		mem_wd = acc;
		cfg_we = 1'b0;
		dir_we = 1'b0;
		kick = 1'b0;
		stby = 1'b0;
		swrst = 1'b0;
		pc_chg = 1'b0;
		if (exec) begin
			next_st.standby = 1'b0;
			unique case (op)
				mcidec_pkg::OP_JREL: begin
					next_pc = pc + 15'h0001 + {{6{ins[8]}}, ins[8:0]};
					pc_chg = 1'b1;
				end
				mcidec_pkg::OP_BRW: begin
					next_pc = pc + 15'h0001 + {7'h00, acc};
					pc_chg = 1'b1;
				end
				mcidec_pkg::OP_INVOKE, mcidec_pkg::OP_JABS: begin
					next_pc = {pc[14:11], ins[10:0]};
					push = op == mcidec_pkg::OP_INVOKE;
					pc_chg = 1'b1;
				end
				mcidec_pkg::OP_ACC_INDEXED_INVOKE: begin
					next_pc = {pc[14:8], acc};
					push = 1'b1;
					pc_chg = 1'b1;
				end
				mcidec_pkg::OP_RETURN, mcidec_pkg::OP_INTEXIT, mcidec_pkg::OP_RETLIT: begin
					next_sp = sp - 1'b1;
					next_pc = stack[next_sp];
					pc_chg = 1'b1;
					if (op == mcidec_pkg::OP_INTEXIT) next_st.gie = 1'b1;
					if (op == mcidec_pkg::OP_RETLIT) next_acc = ins[7:0];
				end
				mcidec_pkg::OP_KICK: begin
					kick = 1'b1;
					next_st.timeout_flag = 1'b1;
					next_st.power_down_flag = 1'b1;
				end
				mcidec_pkg::OP_STANDBY: begin
					stby = 1'b1;
					next_st.standby = 1'b1;
					next_st.timeout_flag = 1'b1;
					next_st.power_down_flag = 1'b0;
				end
				mcidec_pkg::OP_SWRESET: swrst = 1'b1;
				mcidec_pkg::OP_CONFIG: cfg_we = 1'b1;
				mcidec_pkg::OP_DIR: dir_we = 1'b1;
				mcidec_pkg::OP_PADD: begin
					if (ins[6]) next_ptr1 = ea;
					else next_ptr0 = ea;
				end
				mcidec_pkg::OP_LOAD_MOD, mcidec_pkg::OP_STORE_MOD: begin
					if (ins[2]) next_ptr1 = ptr_step;
					else next_ptr0 = ptr_step;
					if (op == mcidec_pkg::OP_LOAD_MOD) begin
						next_acc = mem_rd;
						next_st.z = mem_rd == 8'h00;
					end else begin
						mem_we = 1'b1;
					end
				end
				mcidec_pkg::OP_LOAD_IDX: begin
					next_acc = mem_rd;
					next_st.z = mem_rd == 8'h00;
				end
				mcidec_pkg::OP_STORE_IDX: mem_we = 1'b1;
				mcidec_pkg::OP_ANDLIT: begin
					next_acc = acc & ins[7:0];
					next_st.z = (acc & ins[7:0]) == 8'h00;
				end
				mcidec_pkg::OP_ADDLIT: begin
					next_acc = sum[7:0];
					next_st.c = sum[8];
					next_st.dc = hsum[4];
					next_st.z = sum[7:0] == 8'h00;
				end
				mcidec_pkg::OP_ANDFILE: begin
					mem_wd = res;
					mem_we = ins[7];
					if (!ins[7]) next_acc = res;
					next_st.z = res == 8'h00;
				end
				mcidec_pkg::OP_IDLE: next_acc = acc;
			endcase
		end else if (w_fire) begin
			next_pc = pc;
			unique case (awaddr)
				mcidec_pkg::OFF_ACC: next_acc = 8'(strb_merge({24'h0, acc}, wdata, wstrb));
				mcidec_pkg::OFF_STATUS: if (wstrb[0]) begin
					next_st.gie = wdata[6];
					next_st.z = wdata[2];
					next_st.dc = wdata[1];
					next_st.c = wdata[0];
				end
				mcidec_pkg::OFF_PTR0: next_ptr0 = 16'(strb_merge({16'h0, ptr0}, wdata, wstrb));
				mcidec_pkg::OFF_PTR1: next_ptr1 = 16'(strb_merge({16'h0, ptr1}, wdata, wstrb));
				mcidec_pkg::OFF_PC: next_pc = 15'(strb_merge({17'h0, pc}, wdata, wstrb));
				mcidec_pkg::OFF_MEM_ADDR:
					next_mem_addr = 16'(strb_merge({16'h0, mem_addr}, wdata, wstrb));
				mcidec_pkg::OFF_MEM_DATA: begin
					mem_we = wstrb[0];
					mem_wa = mem_addr;
					mem_wd = wdata[7:0];
				end
				default: next_pc = pc;
			endcase
		end else begin
			next_pc = pc;
		end
	end

	// The idle second cycle is modelled by holding off the next instruction
	assign cyc = mcidec_pkg::CYC_BASE + (pc_chg ? mcidec_pkg::CYC_EXTRA : 2'h0)
		+ (ind_extra ? mcidec_pkg::CYC_EXTRA : 2'h0);

	always_ff @(posedge aclk) begin
		if (!aresetn || swrst) begin
			acc <= mcidec_pkg::RST_ACC;
			st <= mcidec_pkg::RST_STATUS;
			ptr0 <= mcidec_pkg::RST_PTR;
			ptr1 <= mcidec_pkg::RST_PTR;
			pc <= mcidec_pkg::RST_PC;
			sp <= '0;
			mem_addr <= mcidec_pkg::RST_PTR;
			config_out <= mcidec_pkg::RST_CONFIG;
			standby <= 1'b0;
		end else begin
			acc <= next_acc;
			st <= next_st;
			ptr0 <= next_ptr0;
			ptr1 <= next_ptr1;
			pc <= next_pc;
			sp <= push ? sp + 1'b1 : next_sp;
			mem_addr <= next_mem_addr;
			if (cfg_we) config_out <= acc;
			standby <= next_st.standby;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_cnt <= 2'h0;
			last_cyc <= 2'h0;
			last_ins <= 14'h0000;
			wdt_clear <= 1'b0;
			soft_reset <= 1'b0;
		end else begin
			wdt_clear <= kick;
			soft_reset <= swrst;
			if (exec) begin
				busy_cnt <= cyc - 2'h1;
				last_cyc <= cyc;
				last_ins <= ins;
			end else if (busy_cnt != 2'h0) begin
				busy_cnt <= busy_cnt - 2'h1;
			end
		end
	end

	// No reset on storage arrays; contents are undefined until written
	always_ff @(posedge aclk) begin
		if (push) stack[sp] <= push_val;
		if (mem_we) mem[mem_wa[MAW-1:0]] <= mem_wd;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_dir
			always_ff @(posedge aclk) begin
				if (!aresetn || swrst) begin
					dir_reg[gi] <= mcidec_pkg::RST_DIR;
					dir_out[8*gi +: 8] <= mcidec_pkg::RST_DIR;
				end else if (dir_we && ins[2:0] == 3'(gi)) begin
					dir_reg[gi] <= acc;
					dir_out[8*gi +: 8] <= acc;
				end
			end
		end
	endgenerate
endmodule

// File: design/mcidec_pkg.sv
package mcidec_pkg;
	localparam int ADDR_W = 8;
	localparam int PC_W = 15;
	localparam int PTR_W = 16;
	// ************************
	// Register byte offsets
	// ************************
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_ACC = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_PTR0 = 8'h0C;
	localparam logic [7:0] OFF_PTR1 = 8'h10;
	localparam logic [7:0] OFF_PC = 8'h14;
	localparam logic [7:0] OFF_CONFIG = 8'h18;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h1C;
	localparam logic [7:0] OFF_MEM_DATA = 8'h20;
	localparam logic [7:0] OFF_CYCLES = 8'h24;
	localparam logic [7:0] OFF_DIR_BASE = 8'h40;
	localparam int ST_BUSY = 7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************
	// Reset values and cycle counts
	// ************************
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'hFF;
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [PC_W-1:0] RST_PC = 15'h0000;
	localparam logic [PTR_W-1:0] RST_PTR = 16'h0000;
	localparam logic [1:0] CYC_BASE = 2'h1;
	localparam logic [1:0] CYC_EXTRA = 2'h1;
	// ************************
	// Opcode patterns
	// ************************
	localparam logic [13:0] OPC_IDLE = 14'h0000;
	localparam logic [13:0] OPC_SWRESET = 14'h0001;
	localparam logic [13:0] OPC_RETURN = 14'h0008;
	localparam logic [13:0] OPC_INTEXIT = 14'h0009;
	localparam logic [13:0] OPC_ACC_INDEXED_INVOKE = 14'h000A;
	localparam logic [13:0] OPC_BRW = 14'h000B;
	localparam logic [13:0] OPC_CONFIG = 14'h0062;
	localparam logic [13:0] OPC_STANDBY = 14'h0063;
	localparam logic [13:0] OPC_KICK = 14'h0064;
	localparam logic [10:0] PFX_DIR = 11'h00C;
	localparam logic [9:0] PFX_IND_MOD = 10'h001;
	localparam logic [4:0] PFX_JREL = 5'h19;
	localparam logic [2:0] PFX_INVOKE = 3'h4;
	localparam logic [2:0] PFX_JABS = 3'h5;
	localparam logic [5:0] PFX_RETLIT = 6'h34;
	localparam logic [6:0] PFX_PADD = 7'h62;
	localparam logic [5:0] PFX_IND_IDX = 6'h3F;
	localparam logic [5:0] PFX_ANDLIT = 6'h39;
	localparam logic [5:0] PFX_ADDLIT = 6'h3E;
	localparam logic [5:0] PFX_ANDFILE = 6'h05;
	localparam logic [6:0] F_PORT1 = 7'h01;
	// Pointer update modifier: bit1 selects post, bit0 selects decrement
	localparam logic [1:0] MOD_PRE_INC = 2'h0;
	localparam logic [1:0] MOD_PRE_DEC = 2'h1;
	localparam logic [1:0] MOD_POST_INC = 2'h2;
	localparam logic [1:0] MOD_POST_DEC = 2'h3;
	typedef enum logic [4:0] {
		OP_IDLE = 5'b00000, OP_SWRESET = 5'b00001, OP_RETURN = 5'b00010,
		OP_INTEXIT = 5'b00011, OP_ACC_INDEXED_INVOKE = 5'b00100, OP_BRW = 5'b00101,
		OP_CONFIG = 5'b00110, OP_STANDBY = 5'b00111, OP_KICK = 5'b01000,
		OP_DIR = 5'b01001, OP_LOAD_MOD = 5'b01010, OP_STORE_MOD = 5'b01011,
		OP_JREL = 5'b01100, OP_INVOKE = 5'b01101, OP_JABS = 5'b01110,
		OP_RETLIT = 5'b01111, OP_PADD = 5'b10000, OP_LOAD_IDX = 5'b10001,
		OP_STORE_IDX = 5'b10010, OP_ANDLIT = 5'b10011, OP_ADDLIT = 5'b10100,
		OP_ANDFILE = 5'b10101
	} mcidec_op_t;
	typedef struct packed {
		logic gie;
		logic standby;
		logic timeout_flag;
		logic power_down_flag;
		logic z;
		logic dc;
		logic c;
	} mcidec_status_t;
	localparam mcidec_status_t RST_STATUS = '{gie: 1'b0, standby: 1'b0,
		timeout_flag: 1'b1, power_down_flag: 1'b1, z: 1'b0, dc: 1'b0, c: 1'b0};
endpackage

// File: testbench/mcidec_ext_model.sv
`timescale 1ns/10ps
// ************************
// Watchdog and reset supervisor stand-in
// ************************
module mcidec_ext_model (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic wdt_clear, // Watchdog clear pulse
	input wire logic soft_reset, // Software reset pulse
	output logic [7:0] kick_cnt, // Clears seen
	output logic [7:0] rst_cnt // Resets seen
);
	// Counts survive the core's own software reset, as an outside supervisor would
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kick_cnt <= 8'h00;
			rst_cnt <= 8'h00;
		end else begin
			kick_cnt <= kick_cnt + {7'h00, wdt_clear};
			rst_cnt <= rst_cnt + {7'h00, soft_reset};
		end
	end
endmodule

// File: testbench/mcidec_monitor.sv
`timescale 1ns/10ps
// ************************
// Bus handshake and side-output checks
// ************************
module mcidec_monitor (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic awready, // Write address ready
	input wire logic wready, // Write data ready
	input wire logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [1:0] bresp, // Write response
	input wire logic arready, // Read address ready
	input wire logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	input wire logic [31:0] rdata, // Read data
	input wire logic wdt_clear, // Watchdog clear pulse
	input wire logic standby, // Standby level
	input wire logic soft_reset, // Software reset pulse
	input wire logic [7:0] config_out, // Prescale configuration
	input wire logic [63:0] dir_out // Direction registers
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_aw_w_pair; awready == wready; endproperty
	a_aw_w_pair: assert property (p_aw_w_pair) else $error("write readies split");
	property p_b_follows; awready |=> bvalid && !awready; endproperty
	a_b_follows: assert property (p_b_follows) else $error("no write response");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_kick_pulse; wdt_clear |=> !wdt_clear; endproperty
	a_kick_pulse: assert property (p_kick_pulse) else $error("long clear pulse");
	property p_swrst; soft_reset |=> config_out == 8'hFF && dir_out == {8{8'hFF}}; endproperty
	a_swrst: assert property (p_swrst) else $error("reset left state");
	property p_cfg_cause; !$stable(config_out) |-> $past(awready); endproperty
	a_cfg_cause: assert property (p_cfg_cause) else $error("config moved alone");
	property p_dir_cause; !$stable(dir_out) |-> $past(awready); endproperty
	a_dir_cause: assert property (p_dir_cause) else $error("direction moved alone");
	property p_stby_cause; $rose(standby) |-> $past(awready); endproperty
	a_stby_cause: assert property (p_stby_cause) else $error("standby rose alone");
	cover property (wdt_clear);
	cover property (soft_reset);
	cover property ($rose(standby));
endmodule

// File: testbench/testbench.sv
`timescale 1ns/10ps
// ************************
// Register-driven instruction tests
// ************************
module testbench;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0, a, k, v, kick_cnt, rst_cnt, config_out;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, wdt_clear, standby, soft_reset;
	logic [1:0] bresp, rresp, r, m;
	logic [63:0] dir_out, dx = {8{8'hFF}};
	logic [8:0] s;
	logic [2:0] f;
	logic [15:0] pe, ea;
	int error_cnt = 0, check_count = 0, seed = 28972;
	always #20 aclk = ~aclk;
	mcidec_core mcidec_core_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .wdt_clear, .standby,
		.soft_reset, .config_out, .dir_out);
	mcidec_ext_model mcidec_ext_model_inst (.aclk, .aresetn, .wdt_clear, .soft_reset,
		.kick_cnt, .rst_cnt);
	task print_verdict;
		if (error_cnt == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task tmo(input int n);
		if (n >= 50) begin
			chk("wait", 1, 0);
			print_verdict;
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= ad; wdata <= dt; awvalid <= 1; wvalid <= 1; bready <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 50);
		tmo(n);
		awvalid <= 0; wvalid <= 0;
		n = 0;
		while (bvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
		tmo(n);
		chk("bresp", bresp, er);
		bready <= 0;
	endtask
	task rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= ad; arvalid <= 1; rready <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
		tmo(n);
		arvalid <= 0;
		n = 0;
		while (rvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
		tmo(n);
		dt = rdata; rs = rresp; rready <= 0;
	endtask
	task w(input logic [7:0] ad, input logic [31:0] dt);
		wr(ad, dt, mcidec_pkg::RESP_OKAY);
	endtask
	task ex(input logic [13:0] op);
		w(mcidec_pkg::OFF_INSTR, {18'h0, op});
	endtask
	task rc(input string nm, input logic [7:0] ad, input logic [31:0] e);
		rd(ad, d, r);
		chk(nm, d, e);
	endtask
	function logic [31:0] f_st(input logic c, input logic dc, input logic z);
		return {27'h0, 2'b11, z, dc, c};
	endfunction
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rc("status", mcidec_pkg::OFF_STATUS, 32'h18);
		chk("dir", dir_out, dx);
		rd(8'h3C, d, r);
		chk("rresp", r, mcidec_pkg::RESP_SLVERR);
		wr(mcidec_pkg::OFF_CONFIG, 0, mcidec_pkg::RESP_SLVERR);
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'hFF : 8'($random(seed));
			k = (i == 0) ? 8'h01 : 8'($random(seed));
			w(mcidec_pkg::OFF_ACC, {24'h0, a});
			ex({mcidec_pkg::PFX_ADDLIT, k});
			s = a + k;
			rc("add", mcidec_pkg::OFF_ACC, {24'h0, s[7:0]});
			rc("add st", mcidec_pkg::OFF_STATUS, f_st(s[8], a[3:0] + k[3:0] > 15, s[7:0] == 0));
			ex({mcidec_pkg::PFX_ANDLIT, ~k});
			rc("and", mcidec_pkg::OFF_ACC, {24'h0, s[7:0] & ~k});
			rc("and st", mcidec_pkg::OFF_STATUS,
				f_st(s[8], a[3:0] + k[3:0] > 15, (s[7:0] & ~k) == 0));
			v = 8'($random(seed));
			w(mcidec_pkg::OFF_ACC, {24'h0, v});
			f = 3'(i < 2 ? i : i + 3);
			ex({8'h0C, f});
			dx[8 * f +: 8] = v;
			chk("dir", dir_out, dx);
			ex(mcidec_pkg::OPC_CONFIG);
			chk("config", config_out, v);
		end
		w(mcidec_pkg::OFF_PC, 32'h4123);
		ex({mcidec_pkg::PFX_JABS, 11'h7AB});
		rc("jabs", mcidec_pkg::OFF_PC, 32'h47AB);
		rc("cycles", mcidec_pkg::OFF_CYCLES, 2);
		ex({mcidec_pkg::PFX_JREL, 9'h1F0});
		rc("jrel", mcidec_pkg::OFF_PC, 32'h479C);
		ex({mcidec_pkg::PFX_INVOKE, 11'h055});
		rc("invoke", mcidec_pkg::OFF_PC, 32'h4055);
		ex(mcidec_pkg::OPC_RETURN);
		rc("return", mcidec_pkg::OFF_PC, 32'h479D);
		ex({mcidec_pkg::PFX_INVOKE, 11'h055});
		ex({mcidec_pkg::PFX_RETLIT, 8'h5A});
		rc("retlit", mcidec_pkg::OFF_PC, 32'h479E);
		rc("retlit w", mcidec_pkg::OFF_ACC, 32'h5A);
		ex(mcidec_pkg::OPC_BRW);
		rc("brw", mcidec_pkg::OFF_PC, 32'h47F9);
		ex(mcidec_pkg::OPC_ACC_INDEXED_INVOKE);
		rc("acc_indexed_invoke", mcidec_pkg::OFF_PC, 32'h475A);
		ex(mcidec_pkg::OPC_INTEXIT);
		rc("intexit", mcidec_pkg::OFF_PC, 32'h47FA);
		rc("cycles", mcidec_pkg::OFF_CYCLES, 2);
		w(mcidec_pkg::OFF_PTR0, 32'hFFF0);
		ex({mcidec_pkg::PFX_PADD, 1'b0, 6'h1F});
		rc("padd hi", mcidec_pkg::OFF_PTR0, 32'h000F);
		w(mcidec_pkg::OFF_PTR1, 32'h0005);
		ex({mcidec_pkg::PFX_PADD, 1'b1, 6'h20});
		rc("padd lo", mcidec_pkg::OFF_PTR1, 32'hFFE5);
		rc("cycles", mcidec_pkg::OFF_CYCLES, 1);
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			pe = m[0] ? 16'h1F : 16'h21;
			ea = m[1] ? 16'h20 : pe;
			v = 8'($random(seed)) | 8'h01;
			w(mcidec_pkg::OFF_PTR0, 32'h20);
			w(mcidec_pkg::OFF_ACC, {24'h0, v});
			ex({mcidec_pkg::PFX_IND_MOD, 2'b10, m});
			rc("mod ptr", mcidec_pkg::OFF_PTR0, {16'h0, pe});
			w(mcidec_pkg::OFF_MEM_ADDR, {16'h0, ea});
			rc("store", mcidec_pkg::OFF_MEM_DATA, {24'h0, v});
			w(mcidec_pkg::OFF_PTR0, 32'h20);
			w(mcidec_pkg::OFF_ACC, 0);
			ex({mcidec_pkg::PFX_IND_MOD, 2'b00, m});
			rc("load", mcidec_pkg::OFF_ACC, {24'h0, v});
			rd(mcidec_pkg::OFF_STATUS, d, r);
			chk("load z", d[2], 1'b0);
		end
		w(mcidec_pkg::OFF_PTR1, 32'h8005);
		w(mcidec_pkg::OFF_ACC, 32'hC3);
		ex({mcidec_pkg::PFX_IND_IDX, 2'b11, 6'h03});
		rc("cycles", mcidec_pkg::OFF_CYCLES, 2);
		w(mcidec_pkg::OFF_MEM_ADDR, 32'h08);
		rc("idx st", mcidec_pkg::OFF_MEM_DATA, 32'hC3);
		w(mcidec_pkg::OFF_ACC, 0);
		ex({mcidec_pkg::PFX_IND_IDX, 2'b01, 6'h03});
		rc("idx ld", mcidec_pkg::OFF_ACC, 32'hC3);
		w(mcidec_pkg::OFF_MEM_ADDR, 32'h30);
		w(mcidec_pkg::OFF_MEM_DATA, 32'hF0);
		w(mcidec_pkg::OFF_ACC, 32'h3C);
		ex({mcidec_pkg::PFX_ANDFILE, 1'b1, 7'h30});
		rc("andf f", mcidec_pkg::OFF_MEM_DATA, 32'h30);
		rc("andf w", mcidec_pkg::OFF_ACC, 32'h3C);
		ex({mcidec_pkg::PFX_ANDFILE, 1'b0, 7'h30});
		rc("andf w", mcidec_pkg::OFF_ACC, 32'h30);
		ex(mcidec_pkg::OPC_STANDBY);
		chk("standby", standby, 1);
		rd(mcidec_pkg::OFF_STATUS, d, r);
		chk("sleep st", d[5:3], 3'b110);
		ex(mcidec_pkg::OPC_KICK);
		rd(mcidec_pkg::OFF_STATUS, d, r);
		chk("kick st", d[5:3], 3'b011);
		chk("kicks", kick_cnt, 1);
		ex(mcidec_pkg::OPC_SWRESET);
		chk("config", config_out, 8'hFF);
		rc("pc", mcidec_pkg::OFF_PC, 0);
		chk("resets", rst_cnt, 1);
		print_verdict;
	end
endmodule
bind mcidec_core mcidec_monitor mcidec_monitor_inst (.aclk, .aresetn, .awready, .wready, .bvalid,
	.bready, .bresp, .arready, .rvalid, .rready, .rdata, .wdt_clear, .standby, .soft_reset,
	.config_out, .dir_out);
